// *** logic/ddcf_params.svh ***
/*
 * Offsets, widths and fixed figures of the channel filter configuration bank.
 * Assumes it is included by bare name before the package and the module.
 */
`ifndef DDCF_PARAMS_SVH
`define DDCF_PARAMS_SVH

// ------------------------------------------------------------
// channel addresses
// ------------------------------------------------------------
`define DDCF_A_COEF_TOP 8'h7f
`define DDCF_A_RS_DEC 8'h90
`define DDCF_A_RS_INT 8'h91
`define DDCF_A_RS_SCALE 8'h92
`define DDCF_A_RSVD_RS 8'h93
`define DDCF_A_CB_DEC 8'h94
`define DDCF_A_CB_SCALE 8'h95
`define DDCF_A_RSVD_CB 8'h96
`define DDCF_A_RCF_DEC 8'ha0
`define DDCF_A_RCF_PHASE 8'ha1
`define DDCF_A_RCF_TAPS 8'ha2
`define DDCF_A_RCF_OFFS 8'ha3
`define DDCF_A_RCF_CTRL 8'ha4
`define DDCF_A_ST_I 8'ha5
`define DDCF_A_ST_Q 8'ha6

// ------------------------------------------------------------
// widths
// ------------------------------------------------------------
`define DDCF_ADDR_W 8
`define DDCF_DATA_W 20
`define DDCF_RS_DEC_W 12
`define DDCF_RS_INT_W 9
`define DDCF_ATT_W 5
`define DDCF_BYTE_W 8
`define DDCF_TAPS_W 9
`define DDCF_SAMPLE_W 24
`define DDCF_WORD_W 16
`define DDCF_PORT_W 12
`define DDCF_LI_W 10
`define DDCF_EXP_W 4

// ------------------------------------------------------------
// output formatter figures
// ------------------------------------------------------------
`define DDCF_FIX_SHIFT 11
`define DDCF_FIX_MAX 40'sh00_0000_7fff
`define DDCF_FIX_MIN -40'sh00_0000_8000
`define DDCF_M12_MAX 24'sh0007ff
`define DDCF_M12_MIN -24'sh000800
`define DDCF_M8_MAX 24'sh00007f
`define DDCF_M8_MIN -24'sh000080
`define DDCF_M12_W 12
`define DDCF_M8_W 8
`define DDCF_EXP_MAX 15
`define DDCF_SELF_TEST_LSB 8

`endif

// *** logic/ddcf_pkg.sv ***
/*
 * Types of the channel filter configuration bank.
 * Assumes ddcf_params.svh is on the include path.
 */
`include "ddcf_params.svh"

package ddcf_pkg;

	// resampler attenuation pair
	typedef struct packed {
		logic [`DDCF_ATT_W-1:0] activeAtt;
		logic [`DDCF_ATT_W-1:0] idleAtt;
	} ddcf_rs_scale_s;

	// coefficient filter control word, msb first
	typedef struct packed {
		logic bypass;
		logic inSel;
		logic bank;
		logic commonExp;
		logic forceScale;
		logic [1:0] fmt;
		logic [`DDCF_EXP_W-1:0] scale;
	} ddcf_ctrl_s;

	// programmed configuration
	typedef struct packed {
		logic [`DDCF_RS_DEC_W-1:0] rsDec;
		logic [`DDCF_RS_INT_W-1:0] rsInt;
		ddcf_rs_scale_s rsScale;
		logic [`DDCF_BYTE_W-1:0] combDec;
		logic [`DDCF_ATT_W-1:0] combScale;
		logic [`DDCF_BYTE_W-1:0] rcfDec;
		logic [`DDCF_BYTE_W-1:0] rcfPhase;
		logic [`DDCF_BYTE_W-1:0] rcfTaps;
		logic [`DDCF_BYTE_W-1:0] offsetShadow;
		ddcf_ctrl_s ctrl;
	} ddcf_cfg_s;

	// complex sample
	typedef struct packed {
		logic signed [`DDCF_SAMPLE_W-1:0] i;
		logic signed [`DDCF_SAMPLE_W-1:0] q;
	} ddcf_iq_s;

	// whole module state
	typedef struct packed {
		ddcf_cfg_s cfg;
		logic [`DDCF_PORT_W-1:0] portS1;
		logic [`DDCF_PORT_W-1:0] portS2;
		logic liActive;
		logic [`DDCF_ATT_W-1:0] rsAtt;
		logic [`DDCF_BYTE_W-1:0] phase;
		logic [`DDCF_BYTE_W-1:0] activeOffset;
		logic [`DDCF_TAPS_W-1:0] tapCount;
		ddcf_iq_s rcfIn;
		logic [`DDCF_WORD_W-1:0] stI;
		logic [`DDCF_WORD_W-1:0] stQ;
		logic [`DDCF_DATA_W-1:0] rdData;
		logic coefWrEn;
		logic [`DDCF_BYTE_W-1:0] coefWrAddr;
		logic [`DDCF_DATA_W-1:0] coefWrData;
	} ddcf_state_s;

endpackage

// *** logic/ddcf_channel_filter_config.sv ***
/*
 * Per-channel filter chain configuration bank: resampler, comb decimator and
 * coefficient filter settings, coefficient filter input mux, offset shadow,
 * phase reload, output formatter and self-test capture.
 * Assumes a host port on ref_clk, filter strobes on ref_clk, and the input
 * port word arriving from pins (synchronised here).
 */
// How it works
// - resampler decimation register stores factor minus one, twelve bits up to 4096
// - resampler interpolation register stores factor minus one, nine bits up to 512
// - resampler attenuation: bits 9-5 when level indicator high, bits 4-0 when low
// - comb decimator factor minus one held in eight bits
// - comb decimator five-bit scale offsets internal growth
// - coefficient filter decimation minus one, eight bits, up to 256
// - phase reloaded at each computation start, kept through channel sync
// - tap count presented as register value plus one
// - offset selects starting section of 256-word coefficient memory
// - offset written to shadow, copied to active pointer per output sample
// - bypass sends comb output top sixteen bits to self-test words
// - input select: own comb or other channel comb per fixed map
// - bank bit is address msb for coefficient writes at 0x00-0x7f
// - common exponent from larger magnitude, else separate I and Q exponents
// - forced scale uses bits 3-0 instead of automatic exponent
// - forced scale saturates mantissas rather than wrapping
// - automatic exponent picks best accuracy
// - format bits 5-4: 1x is 12+4, 01 is 8+4, 00 fixed
// - fixed gain is two to the power of scale minus eleven; forced scale shifts mantissas right by scale
// - level indicator high when top ten port bits reach upper threshold
// - with mapping on, formatted or comb output lands in self-test words
`timescale 1ns/1ps
`include "ddcf_params.svh"

module ddcf_channel_filter_config
	import ddcf_pkg::*;
#(
	parameter int CHANNEL = 0
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [`DDCF_ADDR_W-1:0] regAddr,
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [`DDCF_DATA_W-1:0] regWrData,
	output logic [`DDCF_DATA_W-1:0] regRdData,
	input wire logic [`DDCF_PORT_W-1:0] inputPortPin,
	input wire logic [`DDCF_LI_W-1:0] upperThreshold,
	input wire logic mapToSelfTest,
	input wire ddcf_iq_s ownComb,
	input wire ddcf_iq_s otherComb,
	input wire logic combValid,
	input wire ddcf_iq_s rcfOut,
	input wire logic rcfValid,
	input wire logic filterStart,
	input wire logic outputSample,
	output ddcf_cfg_s cfg,
	output logic levelIndicator,
	output logic [`DDCF_ATT_W-1:0] resamplerAttenuation,
	output logic [`DDCF_BYTE_W-1:0] coefFilterPhase,
	output logic [`DDCF_BYTE_W-1:0] coefFilterOffsetPointer,
	output logic [`DDCF_TAPS_W-1:0] coefFilterTapCount,
	output ddcf_iq_s rcfIn,
	output logic [`DDCF_WORD_W-1:0] selfTestWordI,
	output logic [`DDCF_WORD_W-1:0] selfTestWordQ,
	output logic coefWrEn,
	output logic [`DDCF_BYTE_W-1:0] coefWrAddr,
	output logic [`DDCF_DATA_W-1:0] coefWrData
);

	// ------------------------------------------------------------
	// formatter helpers
	// ------------------------------------------------------------

	// smallest exponent whose shifted value fits the mantissa
	function automatic logic [`DDCF_EXP_W-1:0] needExp(input logic signed [`DDCF_SAMPLE_W-1:0] v, input logic wide);
		logic signed [`DDCF_SAMPLE_W-1:0] s;
		logic [`DDCF_EXP_W-1:0] r;
		r = `DDCF_EXP_W'(`DDCF_EXP_MAX);
		for (int e = `DDCF_EXP_MAX; e >= 0; e--) begin
			s = v >>> e;
			if (wide ? (s <= `DDCF_M12_MAX && s >= `DDCF_M12_MIN) : (s <= `DDCF_M8_MAX && s >= `DDCF_M8_MIN)) begin
				r = `DDCF_EXP_W'(e);
			end
		end
		return r;
	endfunction

	// mantissa with clipping, packed with its exponent
	function automatic logic [`DDCF_WORD_W-1:0] packFloat(input logic signed [`DDCF_SAMPLE_W-1:0] v,
		input logic [`DDCF_EXP_W-1:0] e, input logic wide);
		logic signed [`DDCF_SAMPLE_W-1:0] s;
		logic signed [`DDCF_SAMPLE_W-1:0] hi;
		logic signed [`DDCF_SAMPLE_W-1:0] lo;
		s = v >>> e;
		hi = wide ? `DDCF_M12_MAX : `DDCF_M8_MAX;
		lo = wide ? `DDCF_M12_MIN : `DDCF_M8_MIN;
		if (s > hi) begin
			s = hi;
		end else if (s < lo) begin
			s = lo;
		end
		if (wide) begin
			return {s[`DDCF_M12_W-1:0], e};
		end
		return {`DDCF_EXP_W'(0), s[`DDCF_M8_W-1:0], e};
	endfunction

	// fixed point word, gain two to the (scale minus eleven), clipped
	function automatic logic [`DDCF_WORD_W-1:0] packFixed(input logic signed [`DDCF_SAMPLE_W-1:0] v,
		input logic [`DDCF_EXP_W-1:0] sc);
		logic signed [39:0] x;
		x = ($signed(40'(v)) <<< sc) >>> `DDCF_FIX_SHIFT;
		if (x > `DDCF_FIX_MAX) begin
			x = `DDCF_FIX_MAX;
		end else if (x < `DDCF_FIX_MIN) begin
			x = `DDCF_FIX_MIN;
		end
		return x[`DDCF_WORD_W-1:0];
	endfunction

	// ------------------------------------------------------------
	// state and formatter
	// ------------------------------------------------------------
	ddcf_state_s st_q;
	ddcf_state_s st_d;
	logic [`DDCF_EXP_W-1:0] expI;
	logic [`DDCF_EXP_W-1:0] expQ;
	logic [`DDCF_EXP_W-1:0] useI;
	logic [`DDCF_EXP_W-1:0] useQ;
	logic [`DDCF_WORD_W-1:0] fmtI;
	logic [`DDCF_WORD_W-1:0] fmtQ;
	logic wideMant;

	// output formatting of the coefficient filter result
	always_comb begin
		wideMant = st_q.cfg.ctrl.fmt[1];
		expI = needExp(rcfOut.i, wideMant);
		expQ = needExp(rcfOut.q, wideMant);
		if (st_q.cfg.ctrl.forceScale) begin
			useI = st_q.cfg.ctrl.scale;
			useQ = st_q.cfg.ctrl.scale;
		end else if (st_q.cfg.ctrl.commonExp) begin
			useI = (expI > expQ) ? expI : expQ;
			useQ = useI;
		end else begin
			useI = expI;
			useQ = expQ;
		end
		if (st_q.cfg.ctrl.fmt == 2'b00) begin
			fmtI = packFixed(rcfOut.i, st_q.cfg.ctrl.scale);
			fmtQ = packFixed(rcfOut.q, st_q.cfg.ctrl.scale);
		end else begin
			fmtI = packFloat(rcfOut.i, useI, wideMant);
			fmtQ = packFloat(rcfOut.q, useQ, wideMant);
		end
	end

	// next state: host port, level indicator, filter sequencing, capture
	always_comb begin
		st_d = st_q;
		st_d.coefWrEn = 1'b0;
		// two flops on the port word so a pin edge never meets the compare half-settled
		st_d.portS1 = inputPortPin;
		st_d.portS2 = st_q.portS1;
		st_d.liActive = st_q.portS2[`DDCF_PORT_W-1 -: `DDCF_LI_W] >= upperThreshold;
		st_d.rsAtt = st_q.liActive ? st_q.cfg.rsScale.activeAtt : st_q.cfg.rsScale.idleAtt;
		st_d.tapCount = `DDCF_TAPS_W'(st_q.cfg.rcfTaps) + `DDCF_TAPS_W'(1);
		if (filterStart) begin
			st_d.phase = st_q.cfg.rcfPhase;
		end
		// shadow moves only at an output sample, so a host write never tears a running filter
		if (outputSample) begin
			st_d.activeOffset = st_q.cfg.offsetShadow;
		end
		if (combValid) begin
			st_d.rcfIn = st_q.cfg.ctrl.inSel ? otherComb : ownComb;
		end
		if (mapToSelfTest && st_q.cfg.ctrl.bypass && combValid) begin
			st_d.stI = ownComb.i[`DDCF_SAMPLE_W-1 -: `DDCF_WORD_W];
			st_d.stQ = ownComb.q[`DDCF_SAMPLE_W-1 -: `DDCF_WORD_W];
		end else if (mapToSelfTest && !st_q.cfg.ctrl.bypass && rcfValid) begin
			st_d.stI = fmtI;
			st_d.stQ = fmtQ;
		end
		if (regWrEn) begin
			if (regAddr <= `DDCF_A_COEF_TOP) begin
				st_d.coefWrEn = 1'b1;
				st_d.coefWrAddr = {st_q.cfg.ctrl.bank, regAddr[`DDCF_BYTE_W-2:0]};
				st_d.coefWrData = regWrData;
			end
			case (regAddr)
				`DDCF_A_RS_DEC: begin
					st_d.cfg.rsDec = regWrData[`DDCF_RS_DEC_W-1:0];
				end
				`DDCF_A_RS_INT: begin
					st_d.cfg.rsInt = regWrData[`DDCF_RS_INT_W-1:0];
				end
				`DDCF_A_RS_SCALE: begin
					st_d.cfg.rsScale = regWrData[2*`DDCF_ATT_W-1:0];
				end
				`DDCF_A_CB_DEC: begin
					st_d.cfg.combDec = regWrData[`DDCF_BYTE_W-1:0];
				end
				`DDCF_A_CB_SCALE: begin
					st_d.cfg.combScale = regWrData[`DDCF_ATT_W-1:0];
				end
				`DDCF_A_RCF_DEC: begin
					st_d.cfg.rcfDec = regWrData[`DDCF_BYTE_W-1:0];
				end
				`DDCF_A_RCF_PHASE: begin
					st_d.cfg.rcfPhase = regWrData[`DDCF_BYTE_W-1:0];
				end
				`DDCF_A_RCF_TAPS: begin
					st_d.cfg.rcfTaps = regWrData[`DDCF_BYTE_W-1:0];
				end
				`DDCF_A_RCF_OFFS: begin
					st_d.cfg.offsetShadow = regWrData[`DDCF_BYTE_W-1:0];
				end
				`DDCF_A_RCF_CTRL: begin
					st_d.cfg.ctrl = regWrData[$bits(ddcf_ctrl_s)-1:0];
				end
				default: begin
				end
			endcase
		end
		if (regRdEn) begin
			case (regAddr)
				`DDCF_A_RS_DEC: st_d.rdData = `DDCF_DATA_W'(st_q.cfg.rsDec);
				`DDCF_A_RS_INT: st_d.rdData = `DDCF_DATA_W'(st_q.cfg.rsInt);
				`DDCF_A_RS_SCALE: st_d.rdData = `DDCF_DATA_W'(st_q.cfg.rsScale);
				`DDCF_A_CB_DEC: st_d.rdData = `DDCF_DATA_W'(st_q.cfg.combDec);
				`DDCF_A_CB_SCALE: st_d.rdData = `DDCF_DATA_W'(st_q.cfg.combScale);
				`DDCF_A_RCF_DEC: st_d.rdData = `DDCF_DATA_W'(st_q.cfg.rcfDec);
				`DDCF_A_RCF_PHASE: st_d.rdData = `DDCF_DATA_W'(st_q.cfg.rcfPhase);
				`DDCF_A_RCF_TAPS: st_d.rdData = `DDCF_DATA_W'(st_q.cfg.rcfTaps);
				`DDCF_A_RCF_OFFS: st_d.rdData = `DDCF_DATA_W'(st_q.cfg.offsetShadow);
				`DDCF_A_RCF_CTRL: st_d.rdData = `DDCF_DATA_W'(st_q.cfg.ctrl);
				`DDCF_A_ST_I: st_d.rdData = mapToSelfTest ? `DDCF_DATA_W'(st_q.stI) : '0;
				`DDCF_A_ST_Q: st_d.rdData = mapToSelfTest ? `DDCF_DATA_W'(st_q.stQ) : '0;
				default: st_d.rdData = '0;
			endcase
		end
	end

	// state register
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign regRdData = st_q.rdData;
	assign cfg = st_q.cfg;
	assign levelIndicator = st_q.liActive;
	assign resamplerAttenuation = st_q.rsAtt;
	assign coefFilterPhase = st_q.phase;
	assign coefFilterOffsetPointer = st_q.activeOffset;
	assign coefFilterTapCount = st_q.tapCount;
	assign rcfIn = st_q.rcfIn;
	assign selfTestWordI = st_q.stI;
	assign selfTestWordQ = st_q.stQ;
	assign coefWrEn = st_q.coefWrEn;
	assign coefWrAddr = st_q.coefWrAddr;
	assign coefWrData = st_q.coefWrData;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	sequence coefWrite;
		regWrEn && regAddr <= `DDCF_A_COEF_TOP;
	endsequence

	sequence portAboveThr;
		st_q.portS2[`DDCF_PORT_W-1 -: `DDCF_LI_W] >= upperThreshold;
	endsequence

	sequence rsvdWrite;
		regWrEn && (regAddr == `DDCF_A_RSVD_RS || regAddr == `DDCF_A_RSVD_CB);
	endsequence

	sequence gatedStRead;
		regRdEn && !mapToSelfTest && (regAddr == `DDCF_A_ST_I || regAddr == `DDCF_A_ST_Q);
	endsequence

	a_offset_hold: assert property (!outputSample |=> $stable(st_q.activeOffset))
		else $error("active offset moved without an output sample");
	a_offset_load: assert property (outputSample |=> st_q.activeOffset == $past(st_q.cfg.offsetShadow))
		else $error("active offset not taken from shadow");
	a_phase_reload: assert property (filterStart |=> st_q.phase == $past(st_q.cfg.rcfPhase))
		else $error("phase not reloaded at filter start");
	a_phase_hold: assert property (!filterStart |=> $stable(st_q.phase))
		else $error("phase changed outside filter start");
	a_taps_plus_one: assert property ($stable(st_q.cfg.rcfTaps) ##1 $stable(st_q.cfg.rcfTaps)
		|-> coefFilterTapCount == st_q.cfg.rcfTaps + `DDCF_TAPS_W'(1))
		else $error("tap count is not register plus one");
	a_att_select: assert property (st_q.liActive |=> resamplerAttenuation == $past(st_q.cfg.rsScale.activeAtt))
		else $error("active attenuation not applied");
	a_att_idle: assert property (!st_q.liActive |=> resamplerAttenuation == $past(st_q.cfg.rsScale.idleAtt))
		else $error("idle attenuation not applied");
	a_coef_bank: assert property (coefWrite |=> coefWrEn && coefWrAddr[`DDCF_BYTE_W-1] == $past(st_q.cfg.ctrl.bank))
		else $error("coefficient write bank bit wrong");
	a_level_ind: assert property (portAboveThr ##1 $stable(upperThreshold) |-> levelIndicator)
		else $error("level indicator missed threshold");
	a_reserved_zero: assert property (regRdEn && regAddr == `DDCF_A_RSVD_RS |=> regRdData == '0)
		else $error("reserved byte read nonzero");
	a_input_mux: assert property (combValid && st_q.cfg.ctrl.inSel |=> rcfIn == $past(otherComb))
		else $error("other channel comb not selected");
	a_bypass_cap: assert property (mapToSelfTest && st_q.cfg.ctrl.bypass && combValid
		|=> selfTestWordI == $past(ownComb.i[`DDCF_SAMPLE_W-1 -: `DDCF_WORD_W]))
		else $error("bypass capture wrong");

	// register stores land one cycle after the write strobe
	a_dec_store: assert property (regWrEn && regAddr == `DDCF_A_RS_DEC
		|=> cfg.rsDec == $past(regWrData[`DDCF_RS_DEC_W-1:0]))
		else $error("resampler decimation not stored");
	a_int_store: assert property (regWrEn && regAddr == `DDCF_A_RS_INT
		|=> cfg.rsInt == $past(regWrData[`DDCF_RS_INT_W-1:0]))
		else $error("resampler interpolation not stored");
	a_comb_dec: assert property (regWrEn && regAddr == `DDCF_A_CB_DEC
		|=> cfg.combDec == $past(regWrData[`DDCF_BYTE_W-1:0]))
		else $error("comb decimation not stored");
	a_comb_scale: assert property (regWrEn && regAddr == `DDCF_A_CB_SCALE
		|=> cfg.combScale == $past(regWrData[`DDCF_ATT_W-1:0]))
		else $error("comb scale not stored");
	a_rcf_dec: assert property (regWrEn && regAddr == `DDCF_A_RCF_DEC
		|=> cfg.rcfDec == $past(regWrData[`DDCF_BYTE_W-1:0]))
		else $error("coefficient filter decimation not stored");
	a_offs_store: assert property (regWrEn && regAddr == `DDCF_A_RCF_OFFS
		|=> cfg.offsetShadow == $past(regWrData[`DDCF_BYTE_W-1:0]))
		else $error("offset shadow not stored");
	a_ctrl_store: assert property (regWrEn && regAddr == `DDCF_A_RCF_CTRL
		|=> cfg.ctrl == $past(regWrData[$bits(ddcf_ctrl_s)-1:0]))
		else $error("control word not stored");

	// reserved bytes and gated self-test reads
	a_rsvd_write: assert property (rsvdWrite |=> $stable(cfg))
		else $error("reserved byte write changed configuration");
	a_rsvd_cb_zero: assert property (regRdEn && regAddr == `DDCF_A_RSVD_CB |=> regRdData == '0)
		else $error("reserved byte read nonzero");
	a_st_gated: assert property (gatedStRead |=> regRdData == '0)
		else $error("self-test word readable while unmapped");

endmodule // ddcf_channel_filter_config

// *** verif/tb_top.sv ***
/*
 * Self-checking bench for the channel filter configuration bank.
 * Assumes ddcf_params.svh and ddcf_pkg are compiled ahead of this file.
 */
`timescale 1ns/1ps
`include "ddcf_params.svh"

module tb_top
	import ddcf_pkg::*;
;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] regAddr = 8'h00;
	logic regWrEn = 1'b0;
	logic regRdEn = 1'b0;
	logic [19:0] regWrData = 20'h00000;
	logic [19:0] regRdData;
	logic [11:0] inputPortPin = 12'h000;
	logic [9:0] upperThreshold = 10'h200;
	logic mapToSelfTest = 1'b0;
	ddcf_iq_s ownComb = '0;
	ddcf_iq_s otherComb = '0;
	ddcf_iq_s rcfOut = '0;
	ddcf_iq_s rcfIn;
	logic combValid = 1'b0;
	logic rcfValid = 1'b0;
	logic filterStart = 1'b0;
	logic outputSample = 1'b0;
	ddcf_cfg_s cfg;
	logic levelIndicator;
	logic [4:0] resamplerAttenuation;
	logic [7:0] coefFilterPhase;
	logic [7:0] coefFilterOffsetPointer;
	logic [8:0] coefFilterTapCount;
	logic [15:0] selfTestWordI;
	logic [15:0] selfTestWordQ;
	logic coefWrEn;
	logic [7:0] coefWrAddr;
	logic [19:0] coefWrData;
	int errors = 0;
	int comparisons = 0;

	// 125 MHz clock
	always #4 ref_clk = ~ref_clk;

	ddcf_channel_filter_config ddcf_channel_filter_config_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.regAddr(regAddr), .regWrEn(regWrEn), .regRdEn(regRdEn), .regWrData(regWrData),
		.regRdData(regRdData), .inputPortPin(inputPortPin), .upperThreshold(upperThreshold),
		.mapToSelfTest(mapToSelfTest), .ownComb(ownComb), .otherComb(otherComb), .combValid(combValid),
		.rcfOut(rcfOut), .rcfValid(rcfValid), .filterStart(filterStart), .outputSample(outputSample),
		.cfg(cfg), .levelIndicator(levelIndicator), .resamplerAttenuation(resamplerAttenuation),
		.coefFilterPhase(coefFilterPhase), .coefFilterOffsetPointer(coefFilterOffsetPointer),
		.coefFilterTapCount(coefFilterTapCount), .rcfIn(rcfIn), .selfTestWordI(selfTestWordI),
		.selfTestWordQ(selfTestWordQ), .coefWrEn(coefWrEn), .coefWrAddr(coefWrAddr),
		.coefWrData(coefWrData));

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [19:0] d);
		@(posedge ref_clk);
		regWrEn <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge ref_clk);
		regWrEn <= 1'b0;
		#1;
	endtask

	// read data is registered and shows one cycle after the read edge
	task automatic rdchk(input logic [7:0] a, input logic [19:0] exp);
		@(posedge ref_clk);
		regRdEn <= 1'b1;
		regAddr <= a;
		@(posedge ref_clk);
		regRdEn <= 1'b0;
		#1;
		chk(48'(regRdData), 48'(exp));
	endtask

	// one-cycle strobe: 0 comb valid, 1 rcf valid, 2 start, 3 output sample
	task automatic strobe(input int k);
		@(posedge ref_clk);
		case (k)
			0: combValid <= 1'b1;
			1: rcfValid <= 1'b1;
			2: filterStart <= 1'b1;
			default: outputSample <= 1'b1;
		endcase
		@(posedge ref_clk);
		{combValid, rcfValid, filterStart, outputSample} <= 4'h0;
		#1;
	endtask

	task automatic close_out;
		$display("comparisons=%0d errors=%0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	// all-ones then all-zeros (one for 0x90) through 0x90-0x96, 0xa0-0xa4 and unmapped 0x97, reserved bytes written zero
	task automatic t_regs;
		logic [7:0] adr [13] = '{8'h90, 8'h91, 8'h92, 8'h93, 8'h94, 8'h95, 8'h96, 8'ha0, 8'ha1, 8'ha2,
			8'ha3, 8'ha4, 8'h97};
		logic [19:0] msk [13] = '{20'hfff, 20'h1ff, 20'h3ff, 20'h0, 20'hff, 20'h1f, 20'h0, 20'hff, 20'hff,
			20'hff, 20'hff, 20'h7ff, 20'h0};
		// software side keeps reserved bytes and bits 11-10 of 0x92 at zero
		logic [19:0] wd [13] = '{20'hfffff, 20'hfffff, 20'hff3ff, 20'h0, 20'hfffff, 20'hfffff, 20'h0,
			20'hfffff, 20'hfffff, 20'hfffff, 20'hfffff, 20'hfffff, 20'hfffff};
		for (int p = 0; p < 2; p++) begin
			for (int n = 0; n < 13; n++) begin
				wr(adr[n], (p == 0) ? wd[n] : ((n == 0) ? 20'h00001 : 20'h00000));
			end
			for (int n = 0; n < 13; n++) begin
				rdchk(adr[n], (p == 0) ? msk[n] : ((n == 0) ? 20'h00001 : 20'h00000));
			end
			chk(48'(coefFilterTapCount), (p == 0) ? 48'h100 : 48'h001);
		end
		wr(8'h90, 20'h00abc);
		chk(48'(cfg.rsDec), 48'habc);
	endtask

	// level indicator picks which resampler attenuation applies
	task automatic t_level;
		wr(8'h92, 20'h002aa);
		@(posedge ref_clk);
		inputPortPin <= 12'h7fc;
		repeat (6) @(posedge ref_clk);
		#1;
		chk({47'h0, levelIndicator}, 48'h0);
		chk(48'(resamplerAttenuation), 48'h0a);
		@(posedge ref_clk);
		inputPortPin <= 12'h800;
		repeat (6) @(posedge ref_clk);
		#1;
		chk({47'h0, levelIndicator}, 48'h1);
		chk(48'(resamplerAttenuation), 48'h15);
	endtask

	// phase reload on start, offset shadow moved on output sample
	task automatic t_phase_offset;
		wr(8'ha1, 20'h00007);
		chk(48'(coefFilterPhase), 48'h0);
		strobe(2);
		chk(48'(coefFilterPhase), 48'h7);
		wr(8'ha3, 20'h0003c);
		strobe(2);
		chk(48'(coefFilterOffsetPointer), 48'h0);
		strobe(3);
		chk(48'(coefFilterOffsetPointer), 48'h3c);
	endtask

	// bank bit extends coefficient write address
	task automatic t_bank;
		wr(8'ha4, 20'h00100);
		wr(8'h05, 20'habcde);
		chk({39'h0, coefWrEn, coefWrAddr}, {39'h0, 1'b1, 8'h85});
		chk(48'(coefWrData), 48'habcde);
		@(posedge ref_clk);
		#1;
		chk({47'h0, coefWrEn}, 48'h0);
		wr(8'ha4, 20'h00000);
		wr(8'h7f, 20'h12345);
		chk({39'h0, coefWrEn, coefWrAddr}, {39'h0, 1'b1, 8'h7f});
		wr(8'h80, 20'h12345);
		chk({47'h0, coefWrEn}, 48'h0);
	endtask

	// input select, then bypass into the self-test words
	task automatic t_route;
		@(posedge ref_clk);
		ownComb <= {24'h123456, 24'hfedcba};
		otherComb <= {24'h333333, 24'h444444};
		wr(8'ha4, 20'h00200);
		strobe(0);
		chk(rcfIn, otherComb);
		wr(8'ha4, 20'h00000);
		strobe(0);
		chk(rcfIn, ownComb);
		@(posedge ref_clk);
		mapToSelfTest <= 1'b1;
		wr(8'ha4, 20'h00400);
		strobe(0);
		chk(48'({selfTestWordI, selfTestWordQ}), 48'({16'h1234, 16'hfedc}));
		rdchk(8'ha5, 20'h01234);
		rdchk(8'ha6, 20'h0fedc);
		@(posedge ref_clk);
		mapToSelfTest <= 1'b0;
		rdchk(8'ha5, 20'h00000);
	endtask

	// formatted coefficient filter result captured into self-test words
	task automatic fmt(input logic [10:0] c, input logic [47:0] v, input logic [31:0] exp);
		wr(8'ha4, 20'(c));
		@(posedge ref_clk);
		mapToSelfTest <= 1'b1;
		rcfOut <= v;
		strobe(1);
		chk(48'({selfTestWordI, selfTestWordQ}), 48'(exp));
	endtask

	task automatic t_format;
		fmt(11'h003, {24'h001234, 24'hffff00}, {16'h0012, 16'hffff});
		fmt(11'h004, {24'h001234, 24'h000100}, {16'h0024, 16'h0002});
		fmt(11'h00f, {24'h7fffff, 24'h800000}, {16'h7fff, 16'h8000});
		fmt(11'h020, {24'h001000, 24'h000400}, {16'h4002, 16'h4000});
		fmt(11'h030, {24'h001000, 24'h000400}, {16'h4002, 16'h4000});
		fmt(11'h0a0, {24'h001000, 24'h000400}, {16'h4002, 16'h1002});
		fmt(11'h010, {24'h000100, 24'h000010}, {16'h0402, 16'h0100});
		fmt(11'h060, {24'h001000, 24'hfff000}, {16'h7ff0, 16'h8000});
	endtask

	// ------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		repeat (6) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		#1;
		chk(48'(cfg), 48'h0);
		chk(48'(cfg >> 48), 48'h0);
		t_regs();
		t_level();
		t_phase_offset();
		t_bank();
		t_route();
		t_format();
		close_out();
	end

	// the whole sequence needs well under two thousand cycles
	initial begin
		#(20000 * 8);
		errors++;
		close_out();
	end

endmodule // tb_top
